// *** logic/acd_defs.vh ***
/*
 * constants for the auxiliary clock source and divider control block:
 * register byte addresses, field positions, reset values, bus responses.
 * assumes it is included by bare name inside a module body or file top.
 */
`ifndef ACD_DEFS_VH
`define ACD_DEFS_VH

// ============================================================
// register map (byte addresses on the axi4-lite bus)
`define ACD_ADDR_W          8
`define ACD_ADDR_CTRL       8'h00
`define ACD_ADDR_TUNE       8'h04

// ============================================================
// auxiliary clock control fields
`define ACD_CTRL_W          16
`define ACD_BIT_PLL_EN      15
`define ACD_BIT_LOCK        14
`define ACD_BIT_DIV_SRC     13
`define ACD_DIV_HI          10
`define ACD_DIV_LO          8
`define ACD_BIT_REF_PRI     7
`define ACD_BIT_REF_RC      6
`define ACD_CTRL_RESET      16'h2700
`define ACD_CTRL_WMASK      16'ha7c0

// ============================================================
// rc tuning register fields
`define ACD_TUNE_W          6
`define ACD_TUNE_RESET      6'h00
`define ACD_TUNE_STEP_PPM   18'h00ea6
`define ACD_OFFSET_W        18

// ============================================================
// divider code and reference selects
`define ACD_DIV_CODE_W      3
`define ACD_DIV_CODE_MAX    3'h7
`define ACD_DIV_CNT_W       8
`define ACD_REF_NONE        2'h0
`define ACD_REF_PRIMARY     2'h1
`define ACD_REF_RC          2'h2

// ============================================================
// axi4-lite responses
`define ACD_RESP_OKAY       2'h0
`define ACD_RESP_SLVERR     2'h2

`endif

// *** logic/acd_axil_slave.v ***
/*
 * axi4-lite slave front end: takes write address and data in either
 * order, issues one write pulse, then a response; one read at a time.
 * assumes the parent decodes addresses combinationally and returns
 * read data and error flags in the same cycle.
 */
`default_nettype none

`include "acd_defs.vh"

module acd_axil_slave #(
    parameter ADDR_W = 8
) (
    input  wire              core_clk,       // block clock
    input  wire              rst_b,          // async reset, active low
    input  wire [ADDR_W-1:0] s_axi_awaddr,   // write address
    input  wire              s_axi_awvalid,  // write address valid
    output wire              s_axi_awready,  // write address ready
    input  wire [31:0]       s_axi_wdata,    // write data
    input  wire [3:0]        s_axi_wstrb,    // write byte strobes
    input  wire              s_axi_wvalid,   // write data valid
    output wire              s_axi_wready,   // write data ready
    output reg  [1:0]        s_axi_bresp,    // write response
    output reg               s_axi_bvalid,   // write response valid
    input  wire              s_axi_bready,   // write response ready
    input  wire [ADDR_W-1:0] s_axi_araddr,   // read address
    input  wire              s_axi_arvalid,  // read address valid
    output wire              s_axi_arready,  // read address ready
    output reg  [31:0]       s_axi_rdata,    // read data
    output reg  [1:0]        s_axi_rresp,    // read response
    output reg               s_axi_rvalid,   // read data valid
    input  wire              s_axi_rready,   // read data ready
    output wire              wrPulse,        // one-cycle register write
    output reg  [ADDR_W-1:0] wrAddr_ff,      // held write address
    output reg  [31:0]       wrData_ff,      // held write data
    output reg  [3:0]        wrStrb_ff,      // held write strobes
    input  wire              wrErr,          // write address unmapped
    output wire [ADDR_W-1:0] rdAddr,         // read address to decode
    input  wire [31:0]       rdData,         // decoded read data
    input  wire              rdErr           // read address unmapped
);

    reg awHeld_ff;
    reg wHeld_ff;

    // each write channel accepts while its own item is not yet held and no write response is pending
    assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_ff && !s_axi_bvalid;
    assign wrPulse       = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rdAddr        = s_axi_araddr;

    // ============================================================
    // write path
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_ff    <= 1'b0;
            wHeld_ff     <= 1'b0;
            wrAddr_ff    <= {ADDR_W{1'b0}};
            wrData_ff    <= 32'h00000000;
            wrStrb_ff    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ACD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                wrAddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff  <= 1'b1;
                wrData_ff <= s_axi_wdata;
                wrStrb_ff <= s_axi_wstrb;
            end
            // the register update and the response leave together
            if (wrPulse) begin
                awHeld_ff    <= 1'b0;
                wHeld_ff     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrErr ? `ACD_RESP_SLVERR : `ACD_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ============================================================
    // read path: data captured at the address handshake
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `ACD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdErr ? 32'h00000000 : rdData;
            s_axi_rresp  <= rdErr ? `ACD_RESP_SLVERR : `ACD_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** logic/acd_out_divider.v ***
/*
 * power-of-two divider for the auxiliary clock output. counts source
 * ticks and emits one output tick per ratio; code 7 passes every tick.
 * assumes source ticks are one-cycle pulses on the block clock.
 */
`default_nettype none

`include "acd_defs.vh"

module acd_out_divider #(
    parameter CODE_W = 3,
    parameter CNT_W  = 8
) (
    input  wire              core_clk,   // block clock
    input  wire              rst_b,      // async reset, active low
    input  wire              srcTick,    // selected source tick
    input  wire [CODE_W-1:0] divCode,    // divide code
    output reg               divTick_ff, // divided output tick
    output reg               divClk_ff   // divided clock level
);

    reg  [CNT_W-1:0]  count_ff;
    reg  [CODE_W-1:0] codeSeen_ff;
    wire [CODE_W-1:0] shiftAmt;
    wire [CNT_W-1:0]  lastCount;

    // ratio is 2**(7-code); last count is ratio minus one
    assign shiftAmt  = `ACD_DIV_CODE_MAX - divCode;
    assign lastCount = ({{(CNT_W-1){1'b0}}, 1'b1} << shiftAmt)
                       - {{(CNT_W-1){1'b0}}, 1'b1};

    // a new code restarts the count so no short period is seen
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_ff    <= {CNT_W{1'b0}};
            codeSeen_ff <= `ACD_DIV_CODE_MAX;
            divTick_ff  <= 1'b0;
            divClk_ff   <= 1'b0;
        end else begin
            codeSeen_ff <= divCode;
            divTick_ff  <= 1'b0;
            if (codeSeen_ff != divCode) begin
                count_ff <= {CNT_W{1'b0}};
            end else if (srcTick) begin
                if (count_ff >= lastCount) begin
                    count_ff   <= {CNT_W{1'b0}};
                    divTick_ff <= 1'b1;
                    divClk_ff  <= !divClk_ff;
                end else begin
                    count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** logic/acd_aux_clock_ctrl.v ***
/*
 * auxiliary clock source and divider control: holds the auxiliary
 * clock control and rc tuning registers behind an axi4-lite slave,
 * steers the auxiliary pll enable and reference, picks the divider
 * source and runs the output divider.
 * assumes: the analog pll lock pin is asynchronous; source ticks come
 * from logic on core_clk; porRst_b is asserted only at power-on while
 * rst_b is asserted on every reset including power-on.
 */
// Implementation choices: the address map and the AXI4-Lite register port.
`default_nettype none

`include "acd_defs.vh"

module acd_aux_clock_ctrl #(
    parameter ADDR_W = `ACD_ADDR_W
) (
    input  wire              core_clk,       // block clock, 20 MHz
    input  wire              rst_b,          // any reset, active low
    input  wire              porRst_b,       // power-on reset, active low
    input  wire [ADDR_W-1:0] s_axi_awaddr,   // write address
    input  wire              s_axi_awvalid,  // write address valid
    output wire              s_axi_awready,  // write address ready
    input  wire [31:0]       s_axi_wdata,    // write data
    input  wire [3:0]        s_axi_wstrb,    // write byte strobes
    input  wire              s_axi_wvalid,   // write data valid
    output wire              s_axi_wready,   // write data ready
    output wire [1:0]        s_axi_bresp,    // write response
    output wire              s_axi_bvalid,   // write response valid
    input  wire              s_axi_bready,   // write response ready
    input  wire [ADDR_W-1:0] s_axi_araddr,   // read address
    input  wire              s_axi_arvalid,  // read address valid
    output wire              s_axi_arready,  // read address ready
    output wire [31:0]       s_axi_rdata,    // read data
    output wire [1:0]        s_axi_rresp,    // read response
    output wire              s_axi_rvalid,   // read data valid
    input  wire              s_axi_rready,   // read data ready
    input  wire              pllLockPin,     // raw pll lock, async
    input  wire              auxOscTick,     // aux oscillator tick
    input  wire              vcoTick,        // primary pll vco tick
    output reg               auxPllRun_ff,   // pll enable to analog
    output reg  [1:0]        pllRefSel_ff,   // pll reference mux
    output reg               divSrcAux_ff,   // divider source mux
    output wire              auxClkTick,     // divided output tick
    output wire              auxClkOut,      // divided output level
    output reg  [`ACD_TUNE_W-1:0]   rcTuneCode_ff,  // rc trim code
    output reg  [`ACD_OFFSET_W-1:0] rcOffsetPpm_ff, // signed trim ppm
    output reg               auxPllLocked_ff // qualified lock flag
);

    // ============================================================
    // declarations
    // fields, power-on reset only
    reg                        pllEnable_ff;
    reg                        divSrcSel_ff;
    reg  [`ACD_DIV_CODE_W-1:0] divCode_ff;
    reg                        refPrimary_ff;
    reg                        refRc_ff;

    // lock sync and source tick
    reg                        lockMeta_ff;
    reg                        lockSync_ff;
    reg                        srcTick_ff;

    // decode and write merge
    reg  [1:0]                 nxt_pllRefSel;
    reg  [`ACD_CTRL_W-1:0]     ctrlRead;
    reg  [`ACD_CTRL_W-1:0]     ctrlMerged;
    reg  [`ACD_CTRL_W-1:0]     ctrlNew;
    reg  [`ACD_TUNE_W-1:0]     tuneNew;
    reg  [31:0]                rdData;
    reg                        rdErr;
    reg                        wrErr;

    // bus slave side
    wire                       wrPulse;
    wire [ADDR_W-1:0]          wrAddr;
    wire [31:0]                wrData;
    wire [3:0]                 wrStrb;
    wire [ADDR_W-1:0]          rdAddr;
    wire                       wrCtrl;
    wire                       wrTune;
    wire                       refValid;
    wire [`ACD_OFFSET_W-1:0]   tuneSext;

    // ============================================================
    // bus slave
    // one write and one read at a time
    acd_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_slave (
        .core_clk      (core_clk),
        .rst_b         (rst_b),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wrPulse       (wrPulse),
        .wrAddr_ff     (wrAddr),
        .wrData_ff     (wrData),
        .wrStrb_ff     (wrStrb),
        .wrErr         (wrErr),
        .rdAddr        (rdAddr),
        .rdData        (rdData),
        .rdErr         (rdErr)
    );

    // ============================================================
    // address decode; unmapped addresses answer with slverr
    // an error write moves no register
    assign wrCtrl = wrPulse && (wrAddr == `ACD_ADDR_CTRL);
    assign wrTune = wrPulse && (wrAddr == `ACD_ADDR_TUNE);

    always @* begin
        wrErr = (wrAddr != `ACD_ADDR_CTRL) && (wrAddr != `ACD_ADDR_TUNE);
        rdErr = (rdAddr != `ACD_ADDR_CTRL) && (rdAddr != `ACD_ADDR_TUNE);
    end

    // ============================================================
    // control register image; holes stay zero
    // bit 14 shows the qualified flag
    always @* begin
        ctrlRead = {`ACD_CTRL_W{1'b0}};
        ctrlRead[`ACD_BIT_PLL_EN]             = pllEnable_ff;
        ctrlRead[`ACD_BIT_LOCK]               = auxPllLocked_ff;
        ctrlRead[`ACD_BIT_DIV_SRC]            = divSrcSel_ff;
        ctrlRead[`ACD_DIV_HI:`ACD_DIV_LO]     = divCode_ff;
        ctrlRead[`ACD_BIT_REF_PRI]            = refPrimary_ff;
        ctrlRead[`ACD_BIT_REF_RC]             = refRc_ff;
    end

    // byte strobes pick lanes; the mask drops lock and hole bits
    // lanes 31:16 are dropped
    always @* begin
        ctrlMerged = ctrlRead;
        if (wrStrb[0]) begin
            ctrlMerged[7:0] = wrData[7:0];
        end
        if (wrStrb[1]) begin
            ctrlMerged[15:8] = wrData[15:8];
        end
        ctrlNew = ctrlMerged & `ACD_CTRL_WMASK;
        tuneNew = wrStrb[0] ? wrData[`ACD_TUNE_W-1:0] : rcTuneCode_ff;
    end

    // read mux: narrow registers sit in the low bits
    // upper bits always read 0
    always @* begin
        rdData = 32'h00000000;
        if (rdAddr == `ACD_ADDR_CTRL) begin
            rdData[`ACD_CTRL_W-1:0] = ctrlRead;
        end else if (rdAddr == `ACD_ADDR_TUNE) begin
            rdData[`ACD_TUNE_W-1:0] = rcTuneCode_ff;
        end
    end

    // ============================================================
    // control register: like the trim, it survives warm resets
    // a warm reset keeps the setting; the
    // analog copies below drop on rst_b
    always @(posedge core_clk or negedge porRst_b) begin
        if (!porRst_b) begin
            pllEnable_ff  <= 1'b0;
            divSrcSel_ff  <= 1'b1;
            divCode_ff    <= `ACD_DIV_CODE_MAX;
            refPrimary_ff <= 1'b0;
            refRc_ff      <= 1'b0;
        end else if (wrCtrl) begin
            pllEnable_ff  <= ctrlNew[`ACD_BIT_PLL_EN];
            divSrcSel_ff  <= ctrlNew[`ACD_BIT_DIV_SRC];
            divCode_ff    <= ctrlNew[`ACD_DIV_HI:`ACD_DIV_LO];
            refPrimary_ff <= ctrlNew[`ACD_BIT_REF_PRI];
            refRc_ff      <= ctrlNew[`ACD_BIT_REF_RC];
        end
    end

    // ============================================================
    // rc tuning register, cleared by power-on reset alone
    // strobe lane 0 low keeps the code
    always @(posedge core_clk or negedge porRst_b) begin
        if (!porRst_b) begin
            rcTuneCode_ff <= `ACD_TUNE_RESET;
        end else if (wrTune) begin
            rcTuneCode_ff <= tuneNew;
        end
    end

    // signed trim in ppm of nominal: two's complement code times step
    // nominal step; real slope varies
    assign tuneSext = {{(`ACD_OFFSET_W-`ACD_TUNE_W){rcTuneCode_ff[
                        `ACD_TUNE_W-1]}}, rcTuneCode_ff};

    // offset follows the code
    always @(posedge core_clk or negedge porRst_b) begin
        if (!porRst_b) begin
            rcOffsetPpm_ff <= {`ACD_OFFSET_W{1'b0}};
        end else begin
            rcOffsetPpm_ff <= tuneSext * `ACD_TUNE_STEP_PPM;
        end
    end

    // ============================================================
    // pll reference: rc select overrides the primary select
    // both bits set pick the rc path
    always @* begin
        if (refRc_ff) begin
            nxt_pllRefSel = `ACD_REF_RC;
        end else if (refPrimary_ff) begin
            nxt_pllRefSel = `ACD_REF_PRIMARY;
        end else begin
            nxt_pllRefSel = `ACD_REF_NONE;
        end
    end

    // lock needs a chosen reference
    assign refValid = (pllRefSel_ff != `ACD_REF_NONE);

    // analog controls are registered so they never glitch
    // one cycle late but glitch free
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            auxPllRun_ff <= 1'b0;
            pllRefSel_ff <= `ACD_REF_NONE;
            divSrcAux_ff <= 1'b1;
        end else begin
            auxPllRun_ff <= pllEnable_ff;
            pllRefSel_ff <= nxt_pllRefSel;
            divSrcAux_ff <= divSrcSel_ff;
        end
    end

    // ============================================================
    // lock pin synchroniser, then qualified by enable and reference
    // only lockSync_ff reads lockMeta_ff;
    // a lost lock clears in three edges
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lockMeta_ff     <= 1'b0;
            lockSync_ff     <= 1'b0;
            auxPllLocked_ff <= 1'b0;
        end else begin
            lockMeta_ff     <= pllLockPin;
            lockSync_ff     <= lockMeta_ff;
            // a stale analog lock must not show once the pll is off
            auxPllLocked_ff <= lockSync_ff && auxPllRun_ff
                               && refValid;
        end
    end

    // ============================================================
    // divider source mux, registered to give a clean tick
    // a source switch may stretch a period
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            srcTick_ff <= 1'b0;
        end else begin
            srcTick_ff <= divSrcAux_ff ? auxOscTick : vcoTick;
        end
    end

    // output divider; a new code restarts
    // the count and may lose one tick
    acd_out_divider #(
        .CODE_W (`ACD_DIV_CODE_W),
        .CNT_W  (`ACD_DIV_CNT_W)
    ) u_div (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .srcTick    (srcTick_ff),
        .divCode    (divCode_ff),
        .divTick_ff (auxClkTick),
        .divClk_ff  (auxClkOut)
    );

endmodule

`default_nettype wire

// *** testbench/acd_aux_clock_ctrl_chk.sv ***
/*
 * port checker for the auxiliary clock control block.
 * assumes one clock domain and the bind below.
 */
`default_nettype none
module acd_aux_clock_ctrl_chk #(
    parameter ADDR_W = 8
) (
    input wire logic        core_clk,        // clock
    input wire logic        rst_b,           // reset
    input wire logic        s_axi_awvalid,   // aw valid
    input wire logic        s_axi_awready,   // aw ready
    input wire logic        s_axi_wvalid,    // w valid
    input wire logic        s_axi_wready,    // w ready
    input wire logic        s_axi_bvalid,    // b valid
    input wire logic        s_axi_bready,    // b ready
    input wire logic [1:0]  s_axi_bresp,     // b resp
    input wire logic        s_axi_arvalid,   // ar valid
    input wire logic        s_axi_arready,   // ar ready
    input wire logic        s_axi_rvalid,    // r valid
    input wire logic        s_axi_rready,    // r ready
    input wire logic [31:0] s_axi_rdata,     // r data
    input wire logic [1:0]  s_axi_rresp,     // r resp
    input wire logic        pllLockPin,      // raw lock
    input wire logic        auxPllRun_ff,    // pll enable
    input wire logic [1:0]  pllRefSel_ff,    // reference mux
    input wire logic        auxPllLocked_ff, // lock flag
    input wire logic        auxClkTick,      // output tick
    input wire logic        auxClkOut,       // output level
    input wire logic [5:0]  rcTuneCode_ff,   // trim code
    input wire logic [17:0] rcOffsetPpm_ff   // trim offset
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // =====
    // lock flag qualification; the pin goes through two sync flops
    lock_pin_a: assert property (
        auxPllLocked_ff |-> $past(pllLockPin, 3))
        else $error("lock flag without lock pin");
    lock_qual_a: assert property (auxPllLocked_ff |->
        $past(auxPllRun_ff) && $past(pllRefSel_ff) != 2'h0)
        else $error("lock flag not qualified");
    ref_code_a: assert property (pllRefSel_ff != 2'h3)
        else $error("illegal reference select");
    // =====
    // output level toggles exactly with each divided tick
    out_toggle_a: assert property (
        auxClkTick == (auxClkOut != $past(auxClkOut)))
        else $error("output level and tick disagree");
    tune_offset_a: assert property ($stable(rcTuneCode_ff) |->
        rcOffsetPpm_ff == {{12{rcTuneCode_ff[5]}}, rcTuneCode_ff} * 18'h00ea6)
        else $error("trim offset wrong");
    // =====
    // bus answers
    rd_high_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    rd_err_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
        s_axi_rdata == 32'h0) else $error("error read with data");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
endmodule
bind acd_aux_clock_ctrl acd_aux_clock_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// *** testbench/acd_aux_clock_ctrl_tb.sv ***
/*
 * self-checking bench for the auxiliary clock control block.
 * assumes the design and checker files are compiled first.
 */
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module acd_aux_clock_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = '0, rst_b = '0, porRst_b = '0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = '1;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pllRefSel_ff;
    logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic        s_axi_arvalid = '0, s_axi_rready = '0, pllLockPin = '0;
    logic        auxOscTick = '0, vcoTick = '0, auxPllLocked_ff, auxClkOut;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, auxPllRun_ff, divSrcAux_ff, auxClkTick;
    logic [5:0]  rcTuneCode_ff;
    logic [17:0] rcOffsetPpm_ff;
    int          error_cnt = 0, compares = 0, ticks = 0, i;
    acd_aux_clock_ctrl #(.ADDR_W(8)) DUT (.*);
    always #25 core_clk = ~core_clk;
    // count divided output ticks; cleared only while the source is idle
    always @(posedge core_clk) if (auxClkTick === 1'h1) ticks++;
    // =====
    // closing verdict, also reached by any exhausted wait
    task automatic report_and_stop();
        if (error_cnt == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic hang(input int n);
        if (n > 200) begin
            error_cnt++;
            $display("[FAIL] %0t bus timeout", $time);
            report_and_stop();
        end
    endtask
    // =====
    // bus master: address and data offered together, released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; !(s_axi_bvalid && s_axi_bready); n++) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            hang(n);
        end
        `CHK(s_axi_bresp, e)
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; !(s_axi_rvalid && s_axi_rready); n++) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            hang(n);
        end
        `CHK(s_axi_rdata, d)
        `CHK(s_axi_rresp, e)
        s_axi_rready <= 1'h0;
    endtask
    // one-cycle source pulses every other cycle, then settle time
    task automatic burst(input int n, input logic v);
        repeat (n) begin
            @(posedge core_clk);
            auxOscTick <= !v;
            vcoTick <= v;
            @(posedge core_clk);
            auxOscTick <= 1'h0;
            vcoTick <= 1'h0;
        end
        repeat (4) @(posedge core_clk);
    endtask
    task automatic resets(input logic por);
        @(posedge core_clk);
        rst_b <= 1'h0;
        porRst_b <= !por;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'h1;
        porRst_b <= 1'h1;
    endtask
    // =====
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'h1;
        porRst_b <= 1'h1;
        rd(8'h00, 32'h2700, 2'h0);
        rd(8'h04, 32'h0, 2'h0);
        wr(8'h00, 32'hffffffff, 2'h0);
        rd(8'h00, 32'ha7c0, 2'h0);
        `CHK(auxPllRun_ff, 1'h1)
        `CHK(divSrcAux_ff, 1'h1)
        pllLockPin <= 1'h1;
        for (i = 0; i < 4; i++) begin
            wr(8'h00, {16'h0, 8'h87, i[1:0], 6'h0}, 2'h0);
            repeat (5) @(posedge core_clk);
            `CHK(pllRefSel_ff, i[0] ? 2'h2 : {1'h0, i[1]})
            `CHK(auxPllLocked_ff, i != 0)
            rd(8'h00, {16'h0, 1'h1, i != 0, 6'h07, i[1:0], 6'h0},
               2'h0);
        end
        pllLockPin <= 1'h0;
        repeat (5) @(posedge core_clk);
        `CHK(auxPllLocked_ff, 1'h0)
        pllLockPin <= 1'h1;
        wr(8'h00, 32'h00c0, 2'h0);
        repeat (5) @(posedge core_clk);
        `CHK(auxPllRun_ff, 1'h0)
        `CHK(auxPllLocked_ff, 1'h0)
        for (i = 0; i < 8; i++) begin
            wr(8'h00, {16'h0, 5'h04, i[2:0], 8'h0}, 2'h0);
            ticks = 0;
            burst(2 << (7 - i), 1'h0);
            `CHK(ticks, 2)
        end
        wr(8'h00, 32'h0600, 2'h0);
        @(posedge core_clk);
        `CHK(divSrcAux_ff, 1'h0)
        ticks = 0;
        burst(4, 1'h0);
        `CHK(ticks, 0)
        burst(4, 1'h1);
        `CHK(ticks, 2)
        wr(8'h04, 32'h3f, 2'h0);
        rd(8'h04, 32'h3f, 2'h0);
        `CHK(rcOffsetPpm_ff, 18'h3f15a)
        wr(8'h04, 32'hffffff81, 2'h0);
        rd(8'h04, 32'h01, 2'h0);
        `CHK(rcOffsetPpm_ff, 18'h00ea6)
        s_axi_wstrb <= 4'he;
        wr(8'h04, 32'h3e, 2'h0);
        s_axi_wstrb <= 4'hf;
        rd(8'h04, 32'h01, 2'h0);
        // a warm reset must leave both registers alone
        resets(1'h0);
        rd(8'h04, 32'h01, 2'h0);
        rd(8'h00, 32'h0600, 2'h0);
        resets(1'h1);
        rd(8'h04, 32'h0, 2'h0);
        rd(8'h00, 32'h2700, 2'h0);
        wr(8'h08, 32'hffff, 2'h2);
        rd(8'h08, 32'h0, 2'h2);
        report_and_stop();
    end
endmodule
`default_nettype wire
